//--- hdl/pscfg_pkg.sv
/*
 * constants for the power-on strap capture and pin configuration block.
 * assumes a 50 MHz MCLK and a plain strobe register port with 8-bit addresses.
 */
package pscfg_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0]  ADDR_CTRL      = 8'h00;
   localparam logic [7:0]  ADDR_GPIO_OUT  = 8'h04;
   localparam logic [7:0]  ADDR_GPIO_DIR  = 8'h08;
   localparam logic [7:0]  ADDR_GPIO_IN   = 8'h0c;
   localparam logic [7:0]  ADDR_STRAP     = 8'h10;
   localparam logic [31:0] RESET_VALUE    = 32'h0000_0000;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTRL_CARD_ONE   = 0;
   localparam int CTRL_CARD_TWO   = 1;
   localparam int CTRL_FLASH_SEL  = 2;
   localparam int CTRL_W          = 3;
   localparam int GP_PB_LO        = 0;
   localparam int GP_PD0          = 2;
   localparam int GP_PE_LO        = 3;
   localparam int GP_W            = 6;
   localparam int IN_PA_LO        = 8;
   localparam int ST_BOOT_LO      = 0;
   localparam int ST_CLK_MODE     = 2;
   localparam int ST_BOOT_CLK     = 3;
   localparam int ST_DRV_POL_LO   = 4;
   localparam int ST_LCD_ID_LO    = 6;
   localparam int ST_URESET       = 10;
   localparam int ST_TEST_LO      = 11;
   localparam int ST_POR_ACTIVE   = 13;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS      = 20;
   localparam int FLASH_HALF_MS      = 250;
   localparam int FLASH_HALF_CYC     = (FLASH_HALF_MS * 1000000) / CLK_PERIOD_NS;
   localparam logic [1:0] TEST_IDLE  = 2'h3;
endpackage

//--- hdl/pscfg_if.sv
/*
 * carrier between the strap capture module and the pin configuration top.
 * assumes both ends share MCLK.
 */
`timescale 1ns/1ns
interface pscfg_if;
   logic       por_active;
   logic [1:0] boot_width;
   logic       clock_mode;
   logic       boot_clk_opt;
   logic [1:0] drive_pol;
   logic [3:0] lcd_id;
   logic       ureset_cap;
   modport cap (output por_active, boot_width, clock_mode, boot_clk_opt,
                output drive_pol, lcd_id, ureset_cap);
   modport use_side (input por_active, boot_width, clock_mode, boot_clk_opt,
                     input drive_pol, lcd_id, ureset_cap);
endinterface

//--- hdl/pscfg_capture.sv
/*
 * strap capture: watches power_on_reset_n and latches the strap pins on its
 * rising edge. assumes all pin inputs are synchronous to MCLK.
 */
`timescale 1ns/1ns
module pscfg_capture (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       power_on_reset_n,
   input  wire logic [2:0] port_e_in,
   input  wire logic [1:0] drive_in,
   input  wire logic [3:0] lcd_serial_data_in,
   input  wire logic       boot_clk_pin,
   input  wire logic       user_reset_n,
   pscfg_if.cap            cfg
);
   logic       por_seen_reg;
   logic       por_rise;
   logic [1:0] boot_width_reg;
   logic       clock_mode_reg;
   logic       boot_clk_reg;
   logic [1:0] drive_pol_reg;
   logic [3:0] lcd_id_reg;
   logic       ureset_reg;

   // ---------------------------------------------------------------
   // release detection
   // ---------------------------------------------------------------
   // a low pulse shorter than one sampled cycle may be missed
   assign por_rise = ~por_seen_reg & power_on_reset_n;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         por_seen_reg   <= 1'b0;
         boot_width_reg <= 2'h0;
         clock_mode_reg <= 1'b0;
         boot_clk_reg   <= 1'b0;
         drive_pol_reg  <= 2'h0;
         lcd_id_reg     <= 4'h0;
         ureset_reg     <= 1'b1;
      end else if (ce) begin
         por_seen_reg <= power_on_reset_n;
         // only the release edge loads; values then hold
         if (por_rise) begin
            boot_width_reg <= port_e_in[1:0];
            clock_mode_reg <= port_e_in[2];
            boot_clk_reg   <= boot_clk_pin;
            drive_pol_reg  <= drive_in;
            lcd_id_reg     <= lcd_serial_data_in;
            ureset_reg     <= user_reset_n;
         end
      end
   end

   // pins stay inputs until the cycle after the release edge
   assign cfg.por_active   = ~por_seen_reg;
   assign cfg.boot_width   = boot_width_reg;
   assign cfg.clock_mode   = clock_mode_reg;
   assign cfg.boot_clk_opt = boot_clk_reg;
   assign cfg.drive_pol    = drive_pol_reg;
   assign cfg.lcd_id       = lcd_id_reg;
   assign cfg.ureset_cap   = ureset_reg;
endmodule

//--- hdl/pscfg_top.sv
/*
 * pin configuration top: register port, port B/D/E multiplexing, PWM drive
 * polarity, LCD data pins, test mode decode and LED flasher.
 * assumes synchronous pin inputs and a single-cycle strobe master.
 */
`timescale 1ns/1ns
module pscfg_top #(
   parameter int FLASH_HALF_CYC = pscfg_pkg::FLASH_HALF_CYC
) (
   input  wire logic        MCLK,
   input  wire logic        RST,
   input  wire logic        CE,
   input  wire logic        POWER_ON_RESET_N,
   input  wire logic        USER_RESET_N,
   input  wire logic [1:0]  TEST_SELECT,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   input  wire logic [7:0]  PORT_A_BITS,
   input  wire logic [1:0]  PORT_B_IN,
   output logic      [1:0]  PORT_B_OUT,
   output logic      [1:0]  PORT_B_OE,
   input  wire logic        PORT_D_BIT_ZERO_IN,
   output logic             PORT_D_BIT_ZERO_OUT,
   output logic             PORT_D_BIT_ZERO_OE,
   input  wire logic [2:0]  PORT_E_IN,
   output logic      [2:0]  PORT_E_OUT,
   output logic      [2:0]  PORT_E_OE,
   input  wire logic [1:0]  PWM_IN,
   input  wire logic [1:0]  DRIVE_IN,
   output logic      [1:0]  DRIVE_OUT,
   output logic      [1:0]  DRIVE_OE,
   input  wire logic [3:0]  LCD_DATA,
   input  wire logic [3:0]  LCD_SERIAL_DATA_IN,
   output logic      [3:0]  LCD_SERIAL_DATA_OUT,
   output logic      [3:0]  LCD_SERIAL_DATA_OE,
   output logic      [1:0]  BOOT_WIDTH,
   output logic             CLOCK_MODE,
   output logic             BOOT_CLK_OPT,
   output logic             CARD_READY_ONE,
   output logic             CARD_READY_TWO,
   output logic             CARD_READY_PA,
   output logic      [7:0]  KEY_ROWS,
   output logic      [1:0]  TEST_MODE
);
   generate
      if (FLASH_HALF_CYC < 1) begin : g_bad_flash
         $error("FLASH_HALF_CYC must be at least one");
      end
      // the input word packs the gpio field under port A at a fixed place
      if (pscfg_pkg::GP_W != 6 || pscfg_pkg::CTRL_W > 32) begin : g_bad_fields
         $error("register field widths do not fit the word layout");
      end
   endgenerate

   localparam int GW = pscfg_pkg::GP_W;
   localparam int CW = pscfg_pkg::CTRL_W;

   pscfg_if cfg ();

   // straps live in their own module so the hold logic stays in one place
   pscfg_capture u_capture (
      .mclk               (MCLK),
      .rst                (RST),
      .ce                 (CE),
      .power_on_reset_n   (POWER_ON_RESET_N),
      .port_e_in          (PORT_E_IN),
      .drive_in           (DRIVE_IN),
      .lcd_serial_data_in (LCD_SERIAL_DATA_IN),
      .boot_clk_pin       (PORT_A_BITS[6]),
      .user_reset_n       (USER_RESET_N),
      .cfg                (cfg.cap)
   );

   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   logic [CW-1:0] ctrl_reg;
   logic [GW-1:0] gpio_out_reg;
   logic [GW-1:0] gpio_dir_reg;
   logic [31:0]   rdata_reg;
   logic [31:0]   rdata_next;
   logic [GW-1:0] gpio_in;
   logic [31:0]   strap_word;
   logic          card_one_en;
   logic          card_two_en;
   logic          flash_sel;
   logic          wr_ctrl;
   logic          wr_gpio_out;
   logic          wr_gpio_dir;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
      hit = (a == ref_addr);
   endfunction

   assign card_one_en = ctrl_reg[pscfg_pkg::CTRL_CARD_ONE];
   assign card_two_en = ctrl_reg[pscfg_pkg::CTRL_CARD_TWO];
   assign flash_sel   = ctrl_reg[pscfg_pkg::CTRL_FLASH_SEL];

   // write decode kept apart so the register processes stay short
   assign wr_ctrl     = WR & hit(ADDR, pscfg_pkg::ADDR_CTRL);
   assign wr_gpio_out = WR & hit(ADDR, pscfg_pkg::ADDR_GPIO_OUT);
   assign wr_gpio_dir = WR & hit(ADDR, pscfg_pkg::ADDR_GPIO_DIR);

   assign gpio_in = {PORT_E_IN, PORT_D_BIT_ZERO_IN, PORT_B_IN};

   assign strap_word = {18'h0, cfg.por_active, TEST_MODE, cfg.ureset_cap,
                        cfg.lcd_id, cfg.drive_pol, cfg.boot_clk_opt,
                        cfg.clock_mode, cfg.boot_width};

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   // unmapped addresses read as zero
   assign rdata_next =
      hit(ADDR, pscfg_pkg::ADDR_CTRL)     ? {{(32-CW){1'b0}}, ctrl_reg} :
      hit(ADDR, pscfg_pkg::ADDR_GPIO_OUT) ? {{(32-GW){1'b0}}, gpio_out_reg} :
      hit(ADDR, pscfg_pkg::ADDR_GPIO_DIR) ? {{(32-GW){1'b0}}, gpio_dir_reg} :
      hit(ADDR, pscfg_pkg::ADDR_GPIO_IN)  ? {16'h0, PORT_A_BITS, 2'h0, gpio_in} :
      hit(ADDR, pscfg_pkg::ADDR_STRAP)    ? strap_word :
      32'h0000_0000;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ctrl_reg <= CW'(pscfg_pkg::RESET_VALUE);
      end else if (CE && wr_ctrl) begin
         ctrl_reg <= WDATA[CW-1:0];
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         gpio_out_reg <= GW'(pscfg_pkg::RESET_VALUE);
      end else if (CE && wr_gpio_out) begin
         gpio_out_reg <= WDATA[GW-1:0];
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         gpio_dir_reg <= GW'(pscfg_pkg::RESET_VALUE);
      end else if (CE && wr_gpio_dir) begin
         gpio_dir_reg <= WDATA[GW-1:0];
      end
   end

   // read data last one enabled cycle; the next CE cycle without RD clears the port to zero
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         rdata_reg <= pscfg_pkg::RESET_VALUE;
      end else if (CE) begin
         rdata_reg <= RD ? rdata_next : 32'h0000_0000;
      end
   end

   assign RDATA = rdata_reg;

   // ---------------------------------------------------------------
   // LED flasher
   // ---------------------------------------------------------------
   logic [31:0] flash_cnt_reg;
   logic        flash_wave_reg;
   logic        flash_wrap;
   logic [31:0] flash_cnt_next;

   // free-running, so the first half period after select may be short
   assign flash_wrap     = (flash_cnt_reg == 32'(FLASH_HALF_CYC - 1));
   assign flash_cnt_next = flash_wrap ? 32'h0 : flash_cnt_reg + 32'h1;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         flash_cnt_reg  <= 32'h0;
         flash_wave_reg <= 1'b0;
      end else if (CE) begin
         flash_cnt_reg  <= flash_cnt_next;
         flash_wave_reg <= flash_wave_reg ^ flash_wrap;
      end
   end

   // ---------------------------------------------------------------
   // pin multiplexing
   // ---------------------------------------------------------------
   logic por_act;
   assign por_act = cfg.por_active;

   // card bits hand port B bits 0 and 1 to the adapters as inputs
   assign PORT_B_OUT     = gpio_out_reg[pscfg_pkg::GP_PB_LO +: 2];
   assign PORT_B_OE[0]   = gpio_dir_reg[pscfg_pkg::GP_PB_LO] & ~card_one_en;
   assign PORT_B_OE[1]   = gpio_dir_reg[pscfg_pkg::GP_PB_LO + 1] & ~card_two_en;
   assign CARD_READY_ONE = card_one_en & PORT_B_IN[0];
   assign CARD_READY_TWO = card_two_en & PORT_B_IN[1];

   // flasher shares the pin with the plain output value
   assign PORT_D_BIT_ZERO_OUT = flash_sel ? flash_wave_reg : gpio_out_reg[pscfg_pkg::GP_PD0];
   assign PORT_D_BIT_ZERO_OE  = flash_sel | gpio_dir_reg[pscfg_pkg::GP_PD0];

   // straps are inputs while held in power-on reset
   assign PORT_E_OUT = gpio_out_reg[pscfg_pkg::GP_PE_LO +: 3];
   assign PORT_E_OE  = por_act ? 3'h0 : gpio_dir_reg[pscfg_pkg::GP_PE_LO +: 3];

   // captured polarity: high strap means active-high drive
   // a low strap inverts the raw waveform bit by bit
   logic [1:0] drive_inv;
   assign drive_inv = ~cfg.drive_pol;
   assign DRIVE_OUT = PWM_IN ^ drive_inv;
   assign DRIVE_OE  = por_act ? 2'h0 : 2'h3;

   assign LCD_SERIAL_DATA_OUT = LCD_DATA;
   assign LCD_SERIAL_DATA_OE  = por_act ? 4'h0 : 4'hf;

   assign BOOT_WIDTH    = cfg.boot_width;
   assign CLOCK_MODE    = cfg.clock_mode;
   assign BOOT_CLK_OPT  = cfg.boot_clk_opt;
   assign CARD_READY_PA = PORT_A_BITS[7];
   assign KEY_ROWS      = PORT_A_BITS;

   // ---------------------------------------------------------------
   // test mode decode
   // ---------------------------------------------------------------
   // test codes only count when user reset was low at release
   assign TEST_MODE = cfg.ureset_cap ? pscfg_pkg::TEST_IDLE : TEST_SELECT;
endmodule

//--- dv/pscfg_top_props.sv
/*
 * checker on the pscfg_top ports: strap capture, pin directions, read port.
 * assumes POWER_ON_RESET_N is held low whenever RST is high.
 */
`timescale 1ns/1ns
module pscfg_top_props (
   input wire logic        MCLK,
   input wire logic        RST,
   input wire logic        CE,
   input wire logic        POWER_ON_RESET_N,
   input wire logic        USER_RESET_N,
   input wire logic        RD,
   input wire logic        CLOCK_MODE,
   input wire logic        BOOT_CLK_OPT,
   input wire logic        CARD_READY_PA,
   input wire logic        CARD_READY_ONE,
   input wire logic        CARD_READY_TWO,
   input wire logic [1:0]  TEST_SELECT,
   input wire logic [1:0]  TEST_MODE,
   input wire logic [1:0]  BOOT_WIDTH,
   input wire logic [1:0]  PORT_B_OE,
   input wire logic [1:0]  DRIVE_IN,
   input wire logic [1:0]  PWM_IN,
   input wire logic [1:0]  DRIVE_OUT,
   input wire logic [1:0]  DRIVE_OE,
   input wire logic [2:0]  PORT_E_IN,
   input wire logic [2:0]  PORT_E_OE,
   input wire logic [3:0]  LCD_DATA,
   input wire logic [3:0]  LCD_SERIAL_DATA_OUT,
   input wire logic [3:0]  LCD_SERIAL_DATA_OE,
   input wire logic [7:0]  PORT_A_BITS,
   input wire logic [7:0]  KEY_ROWS,
   input wire logic [31:0] RDATA
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   sequence por_rise;
      CE && POWER_ON_RESET_N && !$past(POWER_ON_RESET_N);
   endsequence
   por_pins_in_a: assert property (CE && !POWER_ON_RESET_N |=> PORT_E_OE == 3'h0
      && DRIVE_OE == 2'h0 && LCD_SERIAL_DATA_OE == 4'h0) else $error("pins driven in power-on");
   strap_latch_a: assert property (por_rise |=> BOOT_WIDTH == $past(PORT_E_IN[1:0])
      && CLOCK_MODE == $past(PORT_E_IN[2]) && BOOT_CLK_OPT == $past(PORT_A_BITS[6]))
      else $error("strap not latched");
   test_mode_a: assert property (por_rise |=>
      TEST_MODE == ($past(USER_RESET_N) ? 2'h3 : TEST_SELECT)) else $error("test mode wrong");
   drive_pol_a: assert property (por_rise |=> DRIVE_OE == 2'h3
      && DRIVE_OUT == ($past(DRIVE_IN) ~^ PWM_IN)) else $error("drive polarity wrong");
   lcd_out_a: assert property (LCD_SERIAL_DATA_OE == 4'hf |->
      LCD_SERIAL_DATA_OUT == LCD_DATA) else $error("lcd data not carried");
   strap_hold_a: assert property (POWER_ON_RESET_N && $past(POWER_ON_RESET_N)
      && $past(POWER_ON_RESET_N, 2) |-> $stable({BOOT_WIDTH, CLOCK_MODE, BOOT_CLK_OPT}))
      else $error("strap moved");
   card_ready_a: assert property ((CARD_READY_ONE |-> !PORT_B_OE[0])
      and (CARD_READY_TWO |-> !PORT_B_OE[1])) else $error("card pin driven");
   port_a_a: assert property (CARD_READY_PA == PORT_A_BITS[7]
      && KEY_ROWS == PORT_A_BITS) else $error("port a use wrong");
   rdata_idle_a: assert property (CE && !RD |=> RDATA == 32'h0) else $error("read data lingers");
   c_capture: cover property (por_rise);
   c_card: cover property (CARD_READY_ONE);
   c_read: cover property (RDATA != 32'h0);
endmodule

//--- dv/pscfg_board.sv
/*
 * board model: strap resistors on port E, drive, lcd and port B pins.
 * assumes a pin not driven by the block rests at its strap level.
 */
`timescale 1ns/1ns
module pscfg_board (
   input  wire logic [2:0] strap_e,
   input  wire logic [2:0] e_out,
   input  wire logic [2:0] e_oe,
   input  wire logic [1:0] strap_drv,
   input  wire logic [1:0] drv_out,
   input  wire logic [1:0] drv_oe,
   input  wire logic [1:0] strap_b,
   input  wire logic [1:0] b_out,
   input  wire logic [1:0] b_oe,
   input  wire logic [3:0] strap_lcd,
   input  wire logic [3:0] lcd_out,
   input  wire logic [3:0] lcd_oe,
   output logic      [2:0] e_pin,
   output logic      [1:0] drv_pin,
   output logic      [1:0] b_pin,
   output logic      [3:0] lcd_pin
);
   // straps are pulls, so a released pin never shows the last driven value
   assign e_pin   = (e_oe & e_out) | (~e_oe & strap_e);
   assign drv_pin = (drv_oe & drv_out) | (~drv_oe & strap_drv);
   assign b_pin   = (b_oe & b_out) | (~b_oe & strap_b);
   assign lcd_pin = (lcd_oe & lcd_out) | (~lcd_oe & strap_lcd);
endmodule

//--- dv/tb_pscfg_top.sv
/*
 * bench for pscfg_top: two power-on captures, gpio, card ready, flasher.
 * assumes the board model resolves pin levels; flasher period shortened.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module tb_pscfg_top;
   logic        MCLK = 0, RST = 1, CE = 1, POWER_ON_RESET_N = 0, USER_RESET_N = 1;
   logic        WR = 0, RD = 0, PORT_D_BIT_ZERO_OUT, PORT_D_BIT_ZERO_OE, PORT_D_BIT_ZERO_IN;
   logic        CLOCK_MODE, BOOT_CLK_OPT, CARD_READY_ONE, CARD_READY_TWO, CARD_READY_PA;
   logic [1:0]  TEST_SELECT = 2'h0, PWM_IN = 2'h0, s_drv = 2'h0, s_b = 2'h0, tm;
   logic [1:0]  PORT_B_IN, PORT_B_OUT, PORT_B_OE, DRIVE_IN, DRIVE_OUT, DRIVE_OE;
   logic [1:0]  BOOT_WIDTH, TEST_MODE;
   logic [2:0]  s_e = 3'h0, PORT_E_IN, PORT_E_OUT, PORT_E_OE;
   logic [3:0]  s_lcd = 4'h0, LCD_DATA = 4'h6, LCD_SERIAL_DATA_IN;
   logic [3:0]  LCD_SERIAL_DATA_OUT, LCD_SERIAL_DATA_OE;
   logic [7:0]  ADDR = 8'h00, PORT_A_BITS = 8'h00, KEY_ROWS;
   logic [31:0] WDATA = 32'h0, RDATA, d, exp;
   int          bad_count = 0, tests_run = 0, cyc = 0, n;
   assign PORT_D_BIT_ZERO_IN = PORT_D_BIT_ZERO_OUT & PORT_D_BIT_ZERO_OE;
   pscfg_top #(.FLASH_HALF_CYC(4)) i_dut (.*);
   pscfg_board i_board (.strap_e(s_e), .e_out(PORT_E_OUT), .e_oe(PORT_E_OE),
      .strap_drv(s_drv), .drv_out(DRIVE_OUT), .drv_oe(DRIVE_OE), .strap_b(s_b),
      .b_out(PORT_B_OUT), .b_oe(PORT_B_OE), .strap_lcd(s_lcd), .lcd_out(LCD_SERIAL_DATA_OUT),
      .lcd_oe(LCD_SERIAL_DATA_OE), .e_pin(PORT_E_IN), .drv_pin(DRIVE_IN), .b_pin(PORT_B_IN),
      .lcd_pin(LCD_SERIAL_DATA_IN));
   initial begin
      forever #10 MCLK = ~MCLK;
   end
   // ---------------------------------------------------------------
   // bus tasks and closing
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge MCLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge MCLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1;
      v = RDATA;
   endtask
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge MCLK) begin
      PWM_IN <= PWM_IN + 2'h1;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         stop_test();
      end
   end
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      for (int i = 0; i < 2; i++) begin
         RST <= 1'b1;
         POWER_ON_RESET_N <= 1'b0;
         repeat (6) @(posedge MCLK);
         RST <= 1'b0;
         s_e <= i ? 3'h2 : 3'h5;
         s_drv <= i ? 2'h2 : 2'h1;
         s_lcd <= i ? 4'h3 : 4'ha;
         LCD_DATA <= i ? 4'h9 : 4'h6;
         PORT_A_BITS <= i ? 8'h05 : 8'hc5;
         USER_RESET_N <= i[0];
         TEST_SELECT <= i ? 2'h2 : 2'h1;
         repeat (3) @(posedge MCLK);
         rd(pscfg_pkg::ADDR_STRAP, d);
         `CHK(d[13], 1'b1)
         `CHK({PORT_E_OE, DRIVE_OE, LCD_SERIAL_DATA_OE}, 9'h0)
         tm = i ? 2'h3 : TEST_SELECT;
         exp = {18'h0, 1'b0, tm, i[0], s_lcd, s_drv, ~i[0], s_e};
         @(posedge MCLK);
         POWER_ON_RESET_N <= 1'b1;
         repeat (2) @(posedge MCLK);
         rd(pscfg_pkg::ADDR_STRAP, d);
         `CHK(d, exp)
         `CHK({CLOCK_MODE, BOOT_WIDTH, TEST_MODE}, {s_e, tm})
         `CHK({DRIVE_OE, DRIVE_OUT}, {2'h3, s_drv ~^ PWM_IN})
         `CHK({LCD_SERIAL_DATA_OE, LCD_SERIAL_DATA_OUT}, {4'hf, LCD_DATA})
         `CHK({KEY_ROWS, CARD_READY_PA, BOOT_CLK_OPT}, {PORT_A_BITS, PORT_A_BITS[7], ~i[0]})
         s_e <= ~s_e;
         s_lcd <= ~s_lcd;
         PORT_A_BITS <= ~PORT_A_BITS & 8'h7f;
         USER_RESET_N <= ~USER_RESET_N;
         rd(pscfg_pkg::ADDR_STRAP, d);
         `CHK(d, exp)
      end
      wr(pscfg_pkg::ADDR_GPIO_DIR, 32'h3f);
      wr(pscfg_pkg::ADDR_GPIO_OUT, 32'h2a);
      `CHK({PORT_E_OE, PORT_E_OUT, PORT_B_OE}, {3'h7, 3'h5, 2'h3})
      rd(pscfg_pkg::ADDR_GPIO_IN, d);
      `CHK(d, {16'h0, PORT_A_BITS, 8'h2a})
      s_b <= 2'h3;
      wr(pscfg_pkg::ADDR_CTRL, 32'h3);
      `CHK({PORT_B_OE, CARD_READY_ONE, CARD_READY_TWO}, 4'h3)
      s_b <= 2'h1;
      rd(pscfg_pkg::ADDR_CTRL, d);
      `CHK({d, CARD_READY_ONE, CARD_READY_TWO}, {32'h3, 2'h2})
      wr(pscfg_pkg::ADDR_CTRL, 32'h4);
      n = 0;
      repeat (20) begin
         d[0] = PORT_D_BIT_ZERO_OUT;
         @(posedge MCLK);
         #1;
         if (d[0] !== PORT_D_BIT_ZERO_OUT) n++;
      end
      `CHK({PORT_D_BIT_ZERO_OE, n >= 4 && n <= 6}, 2'h3)
      wr(pscfg_pkg::ADDR_CTRL, 32'h0);
      wr(pscfg_pkg::ADDR_GPIO_OUT, 32'h04);
      `CHK({PORT_D_BIT_ZERO_OE, PORT_D_BIT_ZERO_OUT}, 2'h3)
      rd(8'h20, d);
      `CHK(d, 32'h0)
      stop_test();
   end
endmodule
bind pscfg_top pscfg_top_props i_props (.*);
